// File: core/auxiliary_bus_control.sv
// Contract
// R1 - Suppress set: latch strobe only during external moves, code moves, external fetches.
// R2 - While the latch strobe is suppressed, the pin is left weakly pulled high.
// R3 - Suppress clear: strobe every sixth oscillator clock, every third in double speed.
// R4 - Strobe-suppress control is bit 0 of the register at address 8Eh.
// R5 - Bit 7 set disables the weak port pull-ups; cleared enables them.
// R6 - Bit 5 clear: external read and write strobes last 6 clock periods.
// R7 - Bit 5 set: external read and write strobes are stretched longer.
// R8 - Bits 3:2 limit internal expanded RAM to 256, 512, 768 or 1024 bytes.
// R9 - Bit 1 clear steers pointer moves internal; set steers them external.
// R10 - Reset value 0X0X 1100b; register is not bit-addressable.
// R11 - Reserved bits 6 and 4 read undefined; software never writes them one.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module auxiliary_bus_control (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    // AXI4-Lite slave
    input  wire logic [aux_bus_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [aux_bus_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // Core activity
    input  wire logic                       double_speed,
    input  wire logic                       external_move_active,
    input  wire logic                       code_move_active,
    input  wire logic                       external_fetch_active,
    // Address latch strobe pin
    output logic                            ale_out,
    output logic                            ale_oe,
    output logic                            ale_weak_pullup,
    // Port pull-ups
    output logic                            port_pullup_en,
    // Pointer-addressed data moves
    input  wire logic                       xdata_req,
    input  wire logic                       xdata_we,
    input  wire logic [15:0]                xdata_addr,
    output logic                            xdata_ready,
    output logic                            xdata_to_internal,
    output logic                            xdata_to_external,
    output logic [10:0]                     xram_size_limit,
    // External memory strobes
    output logic                            read_strobe_n,
    output logic                            write_strobe_n,
    output logic                            strobe_done
);

    import aux_bus_pkg::*;

    typedef struct packed {
        logic              aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic              w_held;
        logic [7:0]        w_byte;
        logic              w_lane;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
        logic [7:0]        ctrl;
        logic [2:0]        ale_cnt;
        logic              ale;
        logic              ale_drive;
        logic              to_int;
        logic              to_ext;
        logic              last_ext;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic        strobe_busy;
    logic        strobe_start;
    logic        suppress;
    logic        ext_sel;
    logic        stretch;
    logic [1:0]  size_code;
    logic [10:0] limit;
    logic        activity;
    logic [2:0]  ale_period;
    logic        go_internal;
    logic        accept_x;
    logic        do_write;
    logic        do_read;
    logic [31:0] status_word;

    // ****************************************************************
    // Control field decode
    // ****************************************************************
    assign suppress  = s_q.ctrl[BIT_SUPPRESS];                       // R4
    assign ext_sel   = s_q.ctrl[BIT_EXT_SEL];
    assign stretch   = s_q.ctrl[BIT_STRETCH];
    assign size_code = {s_q.ctrl[BIT_SIZE_HI], s_q.ctrl[BIT_SIZE_LO]};
    assign limit     = xram_limit(size_code);                       // R8

    assign activity   = external_move_active | code_move_active | external_fetch_active;
    assign ale_period = double_speed ? ALE_DIV_DOUBLE : ALE_DIV_NORMAL; // R3

    // ****************************************************************
    // Data move steering
    // ****************************************************************
    // One move at a time: a new one waits until the strobe has ended
    assign accept_x    = xdata_req & ~strobe_busy;
    assign go_internal = ~ext_sel & ({5'h00, limit} > xdata_addr);  // R8 R9
    assign strobe_start = accept_x & ~go_internal;                  // R9

    // ****************************************************************
    // Bus handshake
    // ****************************************************************
    assign do_write = s_q.aw_held & s_q.w_held & ~s_q.bvalid;
    assign do_read  = s_axi_arvalid & ~s_q.rvalid;

    always_comb begin
        status_word                                = 32'h0000_0000;
        status_word[ST_BUSY]                       = strobe_busy;
        status_word[ST_ALE_DRIVEN]                 = s_q.ale_drive;
        status_word[ST_LAST_EXT]                   = s_q.last_ext;
        status_word[ST_LIMIT_LO +: 11]             = limit;
    end

    always_comb begin
        s_d        = s_q;
        s_d.to_int = 1'b0;
        s_d.to_ext = 1'b0;

        // Write address and data are taken in either order
        if (s_axi_awvalid && !s_q.aw_held && !s_q.bvalid) begin
            s_d.aw_held = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_held && !s_q.bvalid) begin
            s_d.w_held = 1'b1;
            s_d.w_byte = s_axi_wdata[7:0];
            s_d.w_lane = s_axi_wstrb[0];
        end
        if (do_write) begin
            s_d.aw_held = 1'b0;
            s_d.w_held  = 1'b0;
            s_d.bvalid  = 1'b1;
            if (s_q.aw_addr == AUX_ADDR) begin
                s_d.bresp = RESP_OKAY;
                // Whole byte only; reserved bits never store a one
                if (s_q.w_lane) begin
                    s_d.ctrl = s_q.w_byte & AUX_WMASK;              // R4 R10 R11
                end
            end else if (s_q.aw_addr == STATUS_ADDR) begin
                s_d.bresp = RESP_OKAY;
            end else begin
                s_d.bresp = RESP_SLVERR;
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        if (do_read) begin
            s_d.rvalid = 1'b1;
            if (s_axi_araddr == AUX_ADDR) begin
                s_d.rdata = {24'h000000, s_q.ctrl & AUX_WMASK};      // R11
                s_d.rresp = RESP_OKAY;
            end else if (s_axi_araddr == STATUS_ADDR) begin
                s_d.rdata = status_word;
                s_d.rresp = RESP_OKAY;
            end else begin
                s_d.rdata = 32'h0000_0000;
                s_d.rresp = RESP_SLVERR;
            end
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // Latch strobe divider; a period change restarts cleanly at wrap
        if (s_q.ale_cnt >= ale_period - 3'h1) begin
            s_d.ale_cnt = 3'h0;
        end else begin
            s_d.ale_cnt = s_q.ale_cnt + 3'h1;
        end
        s_d.ale_drive = ~suppress | activity;                      // R1 R2
        s_d.ale       = (s_q.ale_cnt == 3'h0) & (~suppress | activity); // R1 R3

        if (accept_x) begin
            s_d.to_int   = go_internal;                            // R9
            s_d.to_ext   = ~go_internal;                           // R9
            s_d.last_ext = ~go_internal;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q.aw_held   <= 1'b0;
            s_q.aw_addr   <= '0;
            s_q.w_held    <= 1'b0;
            s_q.w_byte    <= 8'h00;
            s_q.w_lane    <= 1'b0;
            s_q.bvalid    <= 1'b0;
            s_q.bresp     <= RESP_OKAY;
            s_q.rvalid    <= 1'b0;
            s_q.rdata     <= 32'h0000_0000;
            s_q.rresp     <= RESP_OKAY;
            s_q.ctrl      <= AUX_RESET;                              // R10
            s_q.ale_cnt   <= 3'h0;
            s_q.ale       <= 1'b0;
            s_q.ale_drive <= 1'b1;
            s_q.to_int    <= 1'b0;
            s_q.to_ext    <= 1'b0;
            s_q.last_ext  <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // External strobe timing
    // ****************************************************************
    strobe_timer u_strobe_timer (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .start          (strobe_start),
        .is_write       (xdata_we),
        .stretch        (stretch),
        .busy           (strobe_busy),
        .read_strobe_n  (read_strobe_n),
        .write_strobe_n (write_strobe_n),
        .done           (strobe_done)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign s_axi_awready = ~s_q.aw_held & ~s_q.bvalid;
    assign s_axi_wready  = ~s_q.w_held & ~s_q.bvalid;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = ~s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rdata   = s_q.rdata;
    assign s_axi_rresp   = s_q.rresp;

    assign ale_out         = s_q.ale;
    assign ale_oe          = s_q.ale_drive;
    assign ale_weak_pullup = ~s_q.ale_drive;                         // R2
    assign port_pullup_en  = ~s_q.ctrl[BIT_PULLUP_DIS];              // R5

    assign xdata_ready       = ~strobe_busy;
    assign xdata_to_internal = s_q.to_int;
    assign xdata_to_external = s_q.to_ext;
    assign xram_size_limit   = limit;

endmodule // auxiliary_bus_control

`default_nettype wire

// File: core/aux_bus_pkg.sv
package aux_bus_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int unsigned        ADDR_W       = 12;
    localparam logic [ADDR_W-1:0]  AUX_INDEX    = 12'h08e;
    localparam logic [ADDR_W-1:0]  STATUS_INDEX = 12'h08f;
    localparam logic [ADDR_W-1:0]  AUX_ADDR     = 12'(AUX_INDEX * 4);
    localparam logic [ADDR_W-1:0]  STATUS_ADDR  = 12'(STATUS_INDEX * 4);

    // ****************************************************************
    // Control field positions and values after reset
    // ****************************************************************
    localparam int unsigned  BIT_SUPPRESS   = 0;
    localparam int unsigned  BIT_EXT_SEL    = 1;
    localparam int unsigned  BIT_SIZE_LO    = 2;
    localparam int unsigned  BIT_SIZE_HI    = 3;
    localparam int unsigned  BIT_STRETCH    = 5;
    localparam int unsigned  BIT_PULLUP_DIS = 7;
    localparam logic [7:0]   AUX_RESET      = 8'h0c;
    localparam logic [7:0]   AUX_WMASK      = 8'haf;

    // ****************************************************************
    // Status field positions
    // ****************************************************************
    localparam int unsigned  ST_BUSY        = 0;
    localparam int unsigned  ST_ALE_DRIVEN  = 1;
    localparam int unsigned  ST_LAST_EXT    = 2;
    localparam int unsigned  ST_LIMIT_LO    = 4;

    // ****************************************************************
    // Cycle counts
    // ****************************************************************
    localparam logic [2:0]   ALE_DIV_NORMAL = 3'h6;
    localparam logic [2:0]   ALE_DIV_DOUBLE = 3'h3;
    localparam logic [4:0]   STROBE_SHORT   = 5'h06;
    localparam logic [4:0]   STROBE_LONG    = 5'h0c;

    localparam logic [1:0]   RESP_OKAY      = 2'h0;
    localparam logic [1:0]   RESP_SLVERR    = 2'h2;

    // Usable internal bytes for a size code: 256 times code plus one
    function automatic logic [10:0] xram_limit(input logic [1:0] size);
        xram_limit = {size, 8'h00} + 11'h100;
    endfunction

endpackage

// File: core/strobe_timer.sv
`timescale 1ns/1ps
`default_nettype none

module strobe_timer (
    input  wire logic  aclk,
    input  wire logic  aresetn,
    input  wire logic  start,
    input  wire logic  is_write,
    input  wire logic  stretch,
    output logic       busy,
    output logic       read_strobe_n,
    output logic       write_strobe_n,
    output logic       done
);

    import aux_bus_pkg::*;

    typedef struct packed {
        logic       active;
        logic [4:0] cnt;
        logic       rd_n;
        logic       wr_n;
        logic       done;
    } timer_t;

    timer_t s_q;
    timer_t s_d;

    // ****************************************************************
    // Strobe length counter
    // ****************************************************************
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (s_q.active) begin
            if (s_q.cnt == 5'h00) begin
                s_d.active = 1'b0;
                s_d.rd_n   = 1'b1;
                s_d.wr_n   = 1'b1;
                s_d.done   = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - 5'h01;
            end
        end else if (start) begin
            // Length latched at start; a later change waits for the next access
            s_d.active = 1'b1;
            s_d.cnt    = (stretch ? STROBE_LONG : STROBE_SHORT) - 5'h01; // R6 R7
            s_d.rd_n   = is_write;
            s_d.wr_n   = ~is_write;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '{active: 1'b0, cnt: 5'h00, rd_n: 1'b1, wr_n: 1'b1, done: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign busy           = s_q.active;
    assign read_strobe_n  = s_q.rd_n;
    assign write_strobe_n = s_q.wr_n;
    assign done           = s_q.done;

endmodule // strobe_timer

`default_nettype wire

// File: tb/auxiliary_bus_control_chk.sv
`timescale 1ns/1ps
`default_nettype none
module auxiliary_bus_control_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ale_out,
    input wire logic ale_oe,
    input wire logic ale_weak_pullup,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic strobe_done,
    input wire logic xdata_req,
    input wire logic xdata_ready,
    input wire logic xdata_to_internal,
    input wire logic xdata_to_external
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************************************************************
    // Pin and strobe relations
    // ****************************************************************
    pullup_mirror_a: assert property (ale_weak_pullup == !ale_oe)
        else $error("weak pull-up not opposite to pin drive");
    ale_single_a: assert property (ale_out |=> !ale_out)
        else $error("latch strobe wider than one cycle");
    ale_driven_a: assert property (ale_out |-> ale_oe)
        else $error("latch strobe pulsed while pin released");
    strobe_excl_a: assert property (read_strobe_n || write_strobe_n)
        else $error("read and write strobes low together");
    strobe_min_a: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*6])
        else $error("read strobe shorter than six cycles");
    strobe_done_a: assert property ($rose(read_strobe_n) || $rose(write_strobe_n)
        |-> strobe_done)
        else $error("no done pulse as strobe ends");
    ext_strobe_a: assert property (xdata_to_external |-> !(read_strobe_n && write_strobe_n))
        else $error("external move without strobe");
    move_answer_a: assert property (xdata_req && xdata_ready
        |=> xdata_to_internal != xdata_to_external)
        else $error("accepted move not steered exactly once");
    busy_refuse_a: assert property (!read_strobe_n |-> !xdata_ready)
        else $error("move accepted while strobe active");
    cover property (xdata_to_external);
    cover property (xdata_to_internal);
    cover property ($rose(ale_weak_pullup));
endmodule // auxiliary_bus_control_chk
`default_nettype wire

// File: tb/ext_memory_model.sv
`timescale 1ns/1ps
`default_nettype none
// External memory side: the block drives strobes only, so the model
// records how long each access strobe stays low.
module ext_memory_model (
    input  wire logic       aclk,
    input  wire logic       read_strobe_n,
    input  wire logic       write_strobe_n,
    output logic [4:0]      last_len
);
    logic [4:0] cnt_q = 5'h00;
    initial last_len = 5'h00;
    always @(posedge aclk) begin
        if (!read_strobe_n || !write_strobe_n) begin
            cnt_q <= cnt_q + 5'h01;
        end else if (cnt_q != 5'h00) begin
            last_len <= cnt_q;
            cnt_q    <= 5'h00;
        end
    end
endmodule // ext_memory_model
`default_nettype wire

// File: tb/auxiliary_bus_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module auxiliary_bus_control_tb;
    import aux_bus_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, double_speed = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0]  rresp, bresp;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [2:0]  act = 3'h0;
    logic        xdata_req = 1'b0, xdata_we = 1'b0;
    logic [15:0] xdata_addr = 16'h0000;
    logic        ale_out, ale_oe, ale_weak_pullup, port_pullup_en, xdata_ready, to_int, to_ext;
    logic [10:0] xram_size_limit;
    logic        read_strobe_n, write_strobe_n, strobe_done;
    logic [4:0]  last_len;
    logic [31:0] seed = 32'hb1ba;
    int          n_errors = 0, checks_done = 0, cycles = 0;

    auxiliary_bus_control i_auxiliary_bus_control (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .double_speed(double_speed), .external_move_active(act[0]),
        .code_move_active(act[1]), .external_fetch_active(act[2]), .ale_out(ale_out),
        .ale_oe(ale_oe), .ale_weak_pullup(ale_weak_pullup), .port_pullup_en(port_pullup_en),
        .xdata_req(xdata_req), .xdata_we(xdata_we), .xdata_addr(xdata_addr),
        .xdata_ready(xdata_ready), .xdata_to_internal(to_int), .xdata_to_external(to_ext),
        .xram_size_limit(xram_size_limit), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .strobe_done(strobe_done));

    ext_memory_model i_ext_memory_model (.aclk(aclk), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .last_len(last_len));

    initial begin
        forever #10 aclk = ~aclk;
    end

    // Generous ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            stop_test();
        end
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    // Usable internal bytes for each size code
    function automatic logic [10:0] exp_limit(input logic [1:0] code);
        case (code)
            2'h0:    return 11'h100;
            2'h1:    return 11'h200;
            2'h2:    return 11'h300;
            default: return 11'h400;
        endcase
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic axw(input logic [11:0] a, input logic [7:0] d);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        chk(bresp, (a == AUX_ADDR || a == STATUS_ADDR) ? RESP_OKAY : RESP_SLVERR);
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic mv(input logic we, input logic [15:0] a, input logic ext);
        xdata_req  <= 1'b1;
        xdata_we   <= we;
        xdata_addr <= a;
        do @(posedge aclk); while (!xdata_ready);
        xdata_req <= 1'b0;
        @(posedge aclk);
        chk(to_ext, ext);
        chk(to_int, !ext);
        if (ext) begin
            do @(posedge aclk); while (!strobe_done);
            @(posedge aclk);
        end
    endtask

    task automatic ale_gap(output int n);
        n = 0;
        do @(posedge aclk); while (!ale_out);
        do begin
            @(posedge aclk);
            n++;
        end while (!ale_out && n < 20);
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        logic [7:0]  v;
        int          n;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axr(AUX_ADDR, d, r);
        chk(d, 32'h0000000c);
        chk(port_pullup_en, 1'b1);
        chk(xram_size_limit, 11'h400);
        axr(12'h010, d, r);
        chk(r, RESP_SLVERR);
        axw(12'h010, 8'h01);
        axr(AUX_ADDR, d, r);
        chk(d, 32'h0000000c);
        axr(STATUS_ADDR, d, r);
        chk(d, 32'h00004002);
        $display("reset and map test done");
        for (int i = 0; i < 6; i++) begin
            v = ((i == 0) ? 8'hff : rnd()) & 8'haf;
            axw(AUX_ADDR, v);
            axr(AUX_ADDR, d, r);
            chk(d, {24'h0, v & 8'haf});
            chk(port_pullup_en, !v[7]);
            chk(xram_size_limit, exp_limit(v[3:2]));
        end
        $display("register test done");
        axw(AUX_ADDR, 8'h0c);
        for (int s = 0; s < 2; s++) begin
            double_speed <= s[0];
            ale_gap(n);
            ale_gap(n);
            chk(n, s ? 3 : 6);
        end
        double_speed <= 1'b0;
        axw(AUX_ADDR, 8'h0d);
        repeat (2) @(posedge aclk);
        n = 0;
        repeat (12) begin
            @(posedge aclk);
            n += ale_out;
        end
        chk(n, 0);
        chk(ale_weak_pullup, 1'b1);
        for (int k = 0; k < 3; k++) begin
            act <= 3'b001 << k;
            ale_gap(n);
            ale_gap(n);
            chk(n, 6);
            chk(ale_oe, 1'b1);
        end
        act <= 3'h0;
        $display("latch strobe test done");
        axw(AUX_ADDR, 8'h0c);
        mv(1'b0, 16'h03ff, 1'b0);
        mv(1'b0, 16'h0400, 1'b1);
        for (int i = 0; i < 6; i++) begin
            v = rnd();
            mv(v[0], {5'h00, v, 3'h0}, v[7]);
            if (v[7]) chk(last_len, 6);
        end
        axw(AUX_ADDR, 8'h00);
        mv(1'b0, 16'h00ff, 1'b0);
        mv(1'b0, 16'h0100, 1'b1);
        axw(AUX_ADDR, 8'h2e);
        mv(1'b1, 16'h0000, 1'b1);
        chk(last_len, 12);
        $display("data move test done");
        stop_test();
    end
endmodule // auxiliary_bus_control_tb

bind auxiliary_bus_control auxiliary_bus_control_chk i_auxiliary_bus_control_chk (
    .aclk(aclk), .aresetn(aresetn), .ale_out(ale_out), .ale_oe(ale_oe),
    .ale_weak_pullup(ale_weak_pullup), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .strobe_done(strobe_done), .xdata_req(xdata_req),
    .xdata_ready(xdata_ready), .xdata_to_internal(xdata_to_internal),
    .xdata_to_external(xdata_to_external));
`default_nettype wire
